// ---- rtl/hprp_pkg.sv ----
// Package of constants for the host read port.
package hprp_pkg;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int ADDR_W = 7;
  localparam int WSEL_W = 2;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] BURST_MAX_32 = 5'h08;
  localparam logic [4:0] BURST_MAX_16 = 5'h10;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
  // Read-to-read waits the host must keep; listed for the bench only.
  localparam int WAIT_FIFO_TO_LEVEL_NS = 135;
  localparam int WAIT_FIFO_TO_LEVEL_READS = 3;
  localparam int WAIT_DROP_TO_DROP_NS = 180;
  localparam int WAIT_DROP_TO_DROP_READS = 4;
  localparam int DUMMY_CYCLE_NS = 45;
  localparam int CLK_PERIOD_NS = 8;
  typedef enum logic [2:0] {
    HPRP_IDLE  = 3'b001,
    HPRP_FETCH = 3'b010,
    HPRP_DRIVE = 3'b100
  } hprp_state_t;
endpackage

// ---- rtl/hprp_sync.sv ----
// Two-stage synchroniser for pin inputs.
`timescale 1ns/10ps
module hprp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // hprp_sync

// ---- rtl/hprp_read_port.sv ----
// Read side of the asynchronous SRAM-like host port: single, burst and direct receive-FIFO reads.
`timescale 1ns/10ps
module hprp_read_port #(
  parameter int DATA_W = hprp_pkg::DATA_W,
  parameter int ADDR_W = hprp_pkg::ADDR_W
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic chip_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic fifo_sel_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic bus_16bit_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_lo_oe_out,
  output logic data_hi_oe_out,
  output logic reg_rd_req_out,
  output logic [ADDR_W-1:0] reg_rd_addr_out,
  input wire logic [DATA_W-1:0] reg_rd_data_in,
  output logic reg_rd_done_out,
  output logic [hprp_pkg::WSEL_W-1:0] rx_fifo_wsel_out,
  input wire logic [DATA_W-1:0] rx_fifo_data_in,
  output logic rx_fifo_pop_out
);
  initial begin
    if (DATA_W != 2 * hprp_pkg::HALF_W || ADDR_W <= hprp_pkg::WSEL_W) begin
      $error("hprp_read_port: unsupported data or address width");
    end
    // Both burst limits must be non-zero, and a half-width burst never holds fewer beats.
    if (hprp_pkg::BURST_MAX_32 == 5'h00 || hprp_pkg::BURST_MAX_16 < hprp_pkg::BURST_MAX_32) begin
      $error("hprp_read_port: unsupported burst limits");
    end
  end

  // Every pin passes two flip-flops, so the host sees read data about four clocks after the
  // strobes fall. A host that wants data sooner must stretch its strobe; the delay was accepted
  // to keep pin noise and metastability away from the state machine.

  localparam int SYNC_W = ADDR_W + 4;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_sync;
  logic cs_n_s;
  logic rd_n_s;
  logic fifo_sel_s;
  logic width16_s;
  logic [ADDR_W-1:0] addr_s;
  logic active;

  // Strobes reset high so no phantom cycle is seen while the chain fills.
  assign pins_raw = {chip_select_n_in, read_strobe_n_in, fifo_sel_in, bus_16bit_in, addr_in};

  hprp_sync #(
    .WIDTH(SYNC_W),
    .RESET_VAL({2'b11, {(SYNC_W - 2){1'b0}}})
  ) u_pin_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign cs_n_s = pins_sync[SYNC_W-1];
  assign rd_n_s = pins_sync[SYNC_W-2];
  assign fifo_sel_s = pins_sync[SYNC_W-3];
  assign width16_s = pins_sync[SYNC_W-4];
  assign addr_s = pins_sync[ADDR_W-1:0];
  assign active = ~cs_n_s & ~rd_n_s;

  hprp_pkg::hprp_state_t state_ff;
  hprp_pkg::hprp_state_t nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic fifo_ff;
  logic wide16_ff;
  logic [4:0] count_ff;
  logic [DATA_W-1:0] data_ff;
  logic [DATA_W-1:0] fetch_word;
  logic [4:0] burst_max;
  logic step;
  logic finish;
  logic open_access;

  // An access opens on the first cycle in which idle logic sees both synchronised strobes low.
  assign open_access = (state_ff == hprp_pkg::HPRP_IDLE) && active;

  assign burst_max = wide16_ff ? hprp_pkg::BURST_MAX_16 : hprp_pkg::BURST_MAX_32;
  // A new address inside a held cycle is one more burst beat; beats past the limit are not served.
  assign step = (state_ff == hprp_pkg::HPRP_DRIVE) && active && (addr_s != addr_ff)
    && (fifo_ff || count_ff < burst_max);
  // Releasing a strobe during the fetch cycle still closes the access, so a started FIFO
  // access is always popped once, even if the host gave up before the data came.
  assign finish = (state_ff != hprp_pkg::HPRP_IDLE) && !active;

  // The fetch state lasts one cycle: it gives the storage side a cycle to answer the request.

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      hprp_pkg::HPRP_IDLE: begin
        if (active) begin
          nxt_state = hprp_pkg::HPRP_FETCH;
        end
      end
      hprp_pkg::HPRP_FETCH: begin
        nxt_state = active ? hprp_pkg::HPRP_DRIVE : hprp_pkg::HPRP_IDLE;
      end
      hprp_pkg::HPRP_DRIVE: begin
        if (!active) begin
          nxt_state = hprp_pkg::HPRP_IDLE;
        end else if (step) begin
          nxt_state = hprp_pkg::HPRP_FETCH;
        end
      end
      default: begin
        nxt_state = hprp_pkg::HPRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_ff <= hprp_pkg::HPRP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Access attributes are latched when an access opens; address and FIFO select are relatched on each burst step, bus width is held.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      addr_ff <= hprp_pkg::ADDR_RESET;
      fifo_ff <= 1'b0;
      wide16_ff <= 1'b0;
    end else if (open_access || step) begin
      addr_ff <= addr_s;
      fifo_ff <= fifo_sel_s;
      // Bus width is taken only when an access opens; a strap that moves mid-burst cannot split lanes.
      if (state_ff == hprp_pkg::HPRP_IDLE) begin
        wide16_ff <= width16_s;
      end
    end
  end

  // The count starts at one because the opening access is itself the first beat.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_ff <= 5'h00;
    end else if (state_ff == hprp_pkg::HPRP_IDLE) begin
      count_ff <= active ? 5'h01 : 5'h00;
    end else if (step) begin
      count_ff <= count_ff + 5'h01;
    end
  end

  // One request per beat, so every register, status FIFO or counter sees exactly one read per beat.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rd_req_out <= 1'b0;
      reg_rd_addr_out <= hprp_pkg::ADDR_RESET;
    end else begin
      reg_rd_req_out <= (open_access || step) && !fifo_sel_s;
      reg_rd_addr_out <= addr_s;
    end
  end

  // In FIFO mode only the word-select bits pass on; the rest of the address is ignored.
  assign rx_fifo_wsel_out = addr_ff[hprp_pkg::WSEL_W-1:0];

  // Upper lanes are zeroed in half-width mode so nothing stale sits behind a disabled driver.
  always_comb begin
    fetch_word = fifo_ff ? rx_fifo_data_in : reg_rd_data_in;
    if (wide16_ff) begin
      fetch_word = {{hprp_pkg::HALF_W{1'b0}}, fetch_word[hprp_pkg::HALF_W-1:0]};
    end
  end

  // The snapshot is taken once per beat, so a running counter cannot change under the host.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      data_ff <= hprp_pkg::DATA_RESET;
    end else if (state_ff == hprp_pkg::HPRP_FETCH && active) begin
      data_ff <= fetch_word;
    end
  end

  assign data_out = data_ff;
  assign data_lo_oe_out = (state_ff == hprp_pkg::HPRP_DRIVE) && active;
  assign data_hi_oe_out = data_lo_oe_out && !wide16_ff;

  // Register side effects fire one cycle after each beat closes, so dependent status lags the read.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reg_rd_done_out <= 1'b0;
    end else begin
      reg_rd_done_out <= (finish || step) && !fifo_ff;
    end
  end

  // The pop must land on the edge that closes the beat: a registered pop would advance the
  // FIFO head one cycle late, and the next burst beat would fetch the word already read.
  // The cost is a combinational strobe towards the FIFO, high for one cycle per closed beat.
  assign rx_fifo_pop_out = (finish || step) && fifo_ff && !reset_in;
endmodule // hprp_read_port

// ---- testbench/hprp_read_port_checker.sv ----
// Assertions on the pins of the host read port.
`timescale 1ns/10ps
module hprp_read_port_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic chip_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic fifo_sel_in,
  input wire logic bus_16bit_in,
  input wire logic [31:0] data_out,
  input wire logic data_lo_oe_out,
  input wire logic data_hi_oe_out,
  input wire logic reg_rd_req_out,
  input wire logic reg_rd_done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence both_low3;
    (!chip_select_n_in && !read_strobe_n_in) [*3];
  endsequence
  chk_hi_lane: assert property (data_hi_oe_out |-> data_lo_oe_out && !bus_16bit_in) else $error("upper lane");
  chk_bus_idle: assert property ((chip_select_n_in && read_strobe_n_in) [*3] |-> !data_lo_oe_out)
    else $error("bus driven while idle");
  chk_req_pulse: assert property (reg_rd_req_out |=> !reg_rd_req_out) else $error("request too long");
  chk_req_drive: assert property (both_low3 ##0 reg_rd_req_out |=> data_lo_oe_out) else $error("no drive");
  chk_done_late: assert property (reg_rd_done_out |-> !data_lo_oe_out) else $error("early done");
  chk_data_hold: assert property (data_lo_oe_out && $past(data_lo_oe_out) |-> $stable(data_out))
    else $error("data moved");
  chk_oe_cause: assert property ($rose(data_lo_oe_out) |-> $past(!chip_select_n_in && !read_strobe_n_in, 3))
    else $error("drive without strobes");
  chk_fifo_noreq: assert property (fifo_sel_in [*4] |-> !reg_rd_req_out) else $error("fifo read hit registers");
endmodule // hprp_read_port_checker

// ---- testbench/hprp_store_model.sv ----
// Storage-side model: register space and receive data FIFO head.
`timescale 1ns/10ps
module hprp_store_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [6:0] reg_rd_addr_in,
  input wire logic [1:0] rx_fifo_wsel_in,
  input wire logic rx_fifo_pop_in,
  output logic [31:0] reg_rd_data_out,
  output logic [31:0] rx_fifo_data_out
);
  logic [23:0] head_ff;
  // Register data depends on the address only, so every burst beat has its own answer.
  assign reg_rd_data_out = {4{1'b1, reg_rd_addr_in}};
  assign rx_fifo_data_out = {head_ff, 6'h00, rx_fifo_wsel_in};
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      head_ff <= 24'h000000;
    end else if (rx_fifo_pop_in) begin
      head_ff <= head_ff + 24'h000001;
    end
  end
endmodule // hprp_store_model

// ---- testbench/hprp_read_port_tb.sv ----
// Self-checking bench for the host read port.
`timescale 1ns/10ps
module hprp_read_port_tb;
  logic clk_in = 0, reset_in = 1, cs_n = 1, rd_n = 1, fs = 0, b16 = 0;
  logic [6:0] addr = 7'h00, raddr;
  logic [31:0] data, rdat, fdat;
  logic lo_oe, hi_oe, req, done, pop;
  logic [1:0] wsel;
  int seed = 32'hdcf7, bad_count = 0, compares = 0, head = 0, n, pulses = 0;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) if (done || pop) pulses <= pulses + 1;
  hprp_read_port hprp_read_port_i (.clk_in(clk_in), .reset_in(reset_in), .chip_select_n_in(cs_n),
    .read_strobe_n_in(rd_n), .fifo_sel_in(fs), .addr_in(addr), .bus_16bit_in(b16), .data_out(data),
    .data_lo_oe_out(lo_oe), .data_hi_oe_out(hi_oe), .reg_rd_req_out(req), .reg_rd_addr_out(raddr),
    .reg_rd_data_in(rdat), .reg_rd_done_out(done), .rx_fifo_wsel_out(wsel), .rx_fifo_data_in(fdat),
    .rx_fifo_pop_out(pop));
  hprp_store_model hprp_store_model_i (.clk_in(clk_in), .reset_in(reset_in), .reg_rd_addr_in(raddr),
    .rx_fifo_wsel_in(wsel), .rx_fifo_pop_in(pop), .reg_rd_data_out(rdat), .rx_fifo_data_out(fdat));
  function automatic logic [31:0] exp_of(input logic f, input logic [6:0] a, input int h, input logic w16);
    logic [31:0] e;
    e = f ? {h[23:0], 6'h00, a[1:0]} : {4{1'b1, a}};
    return w16 ? {16'h0000, e[15:0]} : e;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic burst(input logic f, input logic w16, input int beats);
    logic [6:0] a, ea;
    int lim, p0;
    lim = f ? 1000 : (w16 ? 16 : 8);
    p0 = pulses;
    a = 7'($random(seed));
    ea = a;
    @(posedge clk_in);
    fs <= f;
    b16 <= w16;
    addr <= a;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    for (int i = 0; i < beats; i++) begin
      if (i > 0) begin
        @(posedge clk_in);
        a = a + 7'h01;
        addr <= a;
      end
      // Beats past the burst limit are ignored, so the last accepted beat stays on the bus.
      if (i < lim) ea = a;
      repeat (8) @(posedge clk_in);
      #1;
      chk(data, exp_of(f, ea, head + i, w16));
      chk({30'h0, lo_oe, hi_oe}, {30'h0, 1'b1, !w16});
    end
    @(posedge clk_in);
    if ($random(seed) & 1) cs_n <= 1'b1;
    else rd_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk({31'h0, lo_oe}, 32'h0);
    if (f) head = head + beats;
    @(posedge clk_in);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(32'(pulses - p0), 32'(f ? beats : (beats < lim ? beats : lim)));
    // Idle long enough for the longest read-to-read wait, so no dummy reads are needed.
    repeat (hprp_pkg::WAIT_DROP_TO_DROP_NS / hprp_pkg::CLK_PERIOD_NS + 1) @(posedge clk_in);
  endtask
  task automatic summarize;
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    for (int k = 0; k < 4; k++) burst(k[0], k[1], 1);
    burst(1'b0, 1'b0, 9);
    burst(1'b0, 1'b1, 17);
    burst(1'b1, 1'b1, 10);
    repeat (20) begin
      n = $random(seed);
      burst(n[0], n[1], 1 + n[4:2]);
    end
    summarize;
  end
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
endmodule // hprp_read_port_tb
bind hprp_read_port hprp_read_port_checker hprp_read_port_checker_i (.clk_in(clk_in), .reset_in(reset_in),
  .chip_select_n_in(chip_select_n_in), .read_strobe_n_in(read_strobe_n_in), .fifo_sel_in(fifo_sel_in),
  .bus_16bit_in(bus_16bit_in), .data_out(data_out), .data_lo_oe_out(data_lo_oe_out),
  .data_hi_oe_out(data_hi_oe_out), .reg_rd_req_out(reg_rd_req_out), .reg_rd_done_out(reg_rd_done_out));
